// ### logic/bxb_pkg.sv
package bxb_pkg;
  // ---------------------------------------------------------------
  // Microcycle timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  // One time slot; a microcycle of eight slots lasts 4.0 us
  localparam int unsigned SLOT_NS = 500;
  localparam int unsigned SLOT_CYC = SLOT_NS / CLK_PERIOD_NS;
  localparam logic [4:0] SLOT_CNT_MAX = 5'(SLOT_CYC - 1);
  localparam int unsigned SLOTS_PER_UCYC = 8;
  localparam logic [2:0] SLOT_LAST = 3'(SLOTS_PER_UCYC - 1);
  // Slot indices are zero based: index 0 is time slot 1
  localparam logic [2:0] SLOT_TS1 = 3'h0;
  localparam logic [2:0] SLOT_TS2 = 3'h1;
  localparam logic [2:0] SLOT_TS6 = 3'h5;
  // Read cycle access limits
  localparam int unsigned READ_MIN_NS = 2000;
  localparam int unsigned READ_SKIP1_NS = 6000;
  localparam int unsigned READ_SKIP2_NS = 10000;
  // Fixed restart address of the microprogram after reset
  localparam logic [8:0] START_ADDR = 9'h000;
  localparam logic [8:0] START_ADDR_RST = 9'h000;
  // Top address bit selects peripheral space
  localparam int unsigned SPACE_BIT = 15;
  localparam logic [1:0] WAIT_NONE = 2'h0;
endpackage

// ### logic/bxb_if.sv
`timescale 1ns/1ps
interface bxb_if;
  // Master end
  logic [7:0] m_bus_out;
  logic m_bus_oe;
  logic bus_drive_strobe;
  logic transfer_direction;
  logic running_indicator;
  logic ucyc_marker;
  // Responder end
  logic [7:0] s_bus_out;
  logic s_bus_oe;
  logic receive_acknowledge;
  logic run_n;
  // Resolved shared byte bus
  wire [7:0] byte_exchange_bus;
  assign byte_exchange_bus = m_bus_oe ? m_bus_out :
                             (s_bus_oe ? s_bus_out : 8'hff);

  modport master (
    output m_bus_out, m_bus_oe, bus_drive_strobe, transfer_direction,
    output running_indicator, ucyc_marker,
    input byte_exchange_bus, receive_acknowledge, run_n
  );
  modport responder (
    output s_bus_out, s_bus_oe, receive_acknowledge, run_n,
    input byte_exchange_bus, bus_drive_strobe, transfer_direction,
    input running_indicator, ucyc_marker
  );
endinterface

// ### logic/bxb_master.sv
`timescale 1ns/1ps
module bxb_master (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Read request
  input wire logic i_rd_req,
  input wire logic [15:0] i_rd_addr,
  input wire logic [1:0] i_rd_wait,
  input wire logic i_bus_grant,
  output logic o_rd_busy,
  output logic o_rd_done,
  output logic [7:0] o_rd_data,
  output logic [8:0] o_upc,
  // Bus side
  bxb_if.master bus
);
  // ---------------------------------------------------------------
  // Slot timing
  // ---------------------------------------------------------------
  logic [4:0] sub_reg;
  logic [2:0] slot_reg;
  wire sub_end = (sub_reg == bxb_pkg::SLOT_CNT_MAX);
  wire ucyc_end = sub_end && (slot_reg == bxb_pkg::SLOT_LAST);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sub_reg <= 5'h00;
      slot_reg <= 3'h0;
    end else begin
      sub_reg <= sub_end ? 5'h00 : sub_reg + 5'h01;
      if (sub_end) begin
        slot_reg <= slot_reg + 3'h1;
      end
    end
  end

  // Marker in slots 1 and 2
  logic marker_reg;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      marker_reg <= 1'b0;
    end else begin
      marker_reg <= (slot_reg == bxb_pkg::SLOT_TS1) ||
                    (slot_reg == bxb_pkg::SLOT_TS2);
    end
  end
  assign bus.ucyc_marker = marker_reg;

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  logic run_q_reg;
  logic running_reg;
  logic step_reg;
  wire run_rise = bus.run_n && !run_q_reg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_WAIT = 3'b011,
    ST_SAMPLE = 3'b100
  } bxb_state_type;
  bxb_state_type state_reg;
  bxb_state_type state_next;

  wire in_cycle = (state_reg != ST_IDLE);
  // Stop only at a microcycle boundary outside a bus cycle
  wire may_stop = ucyc_end && !in_cycle;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Run idles high: no false step right after reset
      run_q_reg <= 1'b1;
      running_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      run_q_reg <= bus.run_n;
      if (run_rise) begin
        step_reg <= 1'b1;
      end else if (may_stop && step_reg && !bus.run_n) begin
        step_reg <= 1'b0;
      end
      if (may_stop) begin
        running_reg <= bus.run_n || (step_reg && !o_rd_done);
      end
    end
  end
  assign bus.running_indicator = running_reg;

  // ---------------------------------------------------------------
  // Read sequencer
  // ---------------------------------------------------------------
  logic [15:0] addr_reg;
  logic [1:0] wait_reg;
  logic [7:0] data_reg;
  logic done_reg;
  logic [8:0] upc_reg;
  // Grant means priority is already won
  wire start_ok = i_rd_req && i_bus_grant && running_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ucyc_end && start_ok) begin
          state_next = ST_ADDR_HI;
        end
      end
      ST_ADDR_HI: begin
        if (sub_end && slot_reg == bxb_pkg::SLOT_LAST) begin
          state_next = ST_ADDR_LO;
        end
      end
      ST_ADDR_LO: begin
        if (ucyc_end) begin
          state_next = (wait_reg == bxb_pkg::WAIT_NONE) ?
                       ST_SAMPLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ucyc_end && wait_reg == 2'h1) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (ucyc_end) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      addr_reg <= 16'h0000;
      wait_reg <= 2'h0;
      data_reg <= 8'h00;
      done_reg <= 1'b0;
      upc_reg <= bxb_pkg::START_ADDR_RST;
    end else begin
      state_reg <= state_next;
      done_reg <= 1'b0;
      if (state_reg == ST_IDLE && state_next == ST_ADDR_HI) begin
        addr_reg <= i_rd_addr;
        wait_reg <= i_rd_wait;
      end
      if (state_reg == ST_WAIT && ucyc_end) begin
        wait_reg <= wait_reg - 2'h1;
      end
      // No wait line: idle microcycles give slow devices time
      if (state_reg == ST_SAMPLE && ucyc_end) begin
        data_reg <= bus.byte_exchange_bus;
        done_reg <= 1'b1;
      end
      // Counter stands in for the microprogram address
      if (ucyc_end && running_reg) begin
        upc_reg <= upc_reg + 9'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus drive
  // ---------------------------------------------------------------
  // Strobe rises in slot 2, so the fourth and seventh slots after
  // it land on slots 6 and 1: both receiver styles capture alike
  wire hi_slot = (slot_reg != bxb_pkg::SLOT_TS1);
  wire drive_hi = (state_reg == ST_ADDR_HI) && hi_slot;
  wire drive_lo = (state_reg == ST_ADDR_LO) &&
                  (slot_reg < bxb_pkg::SLOT_TS6);
  assign bus.bus_drive_strobe = drive_hi || drive_lo;
  assign bus.m_bus_oe = drive_hi || drive_lo;
  assign bus.m_bus_out = drive_hi ? addr_reg[15:8] : addr_reg[7:0];
  assign bus.transfer_direction = 1'b0;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_rd_busy = in_cycle;
  assign o_rd_done = done_reg;
  assign o_rd_data = data_reg;
  assign o_upc = upc_reg;
endmodule

// ### logic/bxb_responder.sv
`timescale 1ns/1ps
module bxb_responder (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Device side
  input wire logic i_stop,
  input wire logic [15:0] i_base_addr,
  input wire logic [7:0] i_rd_data,
  output logic [15:0] o_cap_addr,
  output logic o_cap_valid,
  output logic o_selected,
  // Bus side
  bxb_if.responder bus
);
  // ---------------------------------------------------------------
  // Strobe edge shift register
  // ---------------------------------------------------------------
  logic strobe_q_reg;
  logic [4:0] sub_reg;
  logic [7:0] slot_sr_reg;
  wire strobe_rise = bus.bus_drive_strobe && !strobe_q_reg;
  wire sub_end = (sub_reg == bxb_pkg::SLOT_CNT_MAX);
  // Fourth and seventh slots after the slot of the rise
  wire cap_hi = sub_end && slot_sr_reg[4] && bus.bus_drive_strobe;
  wire cap_lo = sub_end && slot_sr_reg[7] && bus.bus_drive_strobe;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strobe_q_reg <= 1'b0;
      sub_reg <= 5'h00;
      slot_sr_reg <= 8'h00;
    end else begin
      strobe_q_reg <= bus.bus_drive_strobe;
      if (strobe_rise) begin
        sub_reg <= 5'h00;
        slot_sr_reg <= 8'h01;
      end else begin
        sub_reg <= sub_end ? 5'h00 : sub_reg + 5'h01;
        if (sub_end) begin
          slot_sr_reg <= {slot_sr_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Address capture and data return
  // ---------------------------------------------------------------
  logic [15:0] addr_reg;
  logic valid_reg;
  logic ack_reg;
  logic sel_reg;
  logic [7:0] data_reg;
  // Full match, top bit too, keeps memory and peripheral space apart
  wire match = ({addr_reg[15:8], bus.byte_exchange_bus} == i_base_addr);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_reg <= 16'h0000;
      valid_reg <= 1'b0;
      ack_reg <= 1'b0;
      sel_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      valid_reg <= cap_lo;
      if (cap_hi) begin
        addr_reg[15:8] <= bus.byte_exchange_bus;
        ack_reg <= 1'b1;
      end else if (cap_lo) begin
        addr_reg[7:0] <= bus.byte_exchange_bus;
        ack_reg <= 1'b1;
      end else if (!bus.bus_drive_strobe) begin
        ack_reg <= 1'b0;
      end
      if (strobe_rise) begin
        sel_reg <= 1'b0;
      end else if (cap_lo) begin
        sel_reg <= match && !bus.transfer_direction;
        data_reg <= i_rd_data;
      end
    end
  end

  // Drive only after the master has released the bus
  wire drive_data = sel_reg && !bus.bus_drive_strobe;
  assign bus.s_bus_oe = drive_data;
  assign bus.s_bus_out = data_reg;
  assign bus.receive_acknowledge = ack_reg;
  assign bus.run_n = !i_stop;
  assign o_cap_addr = addr_reg;
  assign o_cap_valid = valid_reg;
  assign o_selected = sel_reg;
endmodule

// ### tb/bxb_props.sv
`timescale 1ns/1ps
module bxb_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Bus lines
  input wire logic m_bus_oe,
  input wire logic s_bus_oe,
  input wire logic bus_drive_strobe,
  input wire logic transfer_direction,
  input wire logic running_indicator,
  input wire logic ucyc_marker,
  input wire logic receive_acknowledge
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_fetch_dir: assert property (!transfer_direction)
    else $error("direction not fetch");
  chk_one_owner: assert property (!(m_bus_oe && s_bus_oe))
    else $error("two bus drivers");
  chk_strobe_owns: assert property (bus_drive_strobe |-> m_bus_oe)
    else $error("strobe without drive");
  chk_stopped_idle: assert property (
    $rose(bus_drive_strobe) |-> $past(running_indicator))
    else $error("bus used while stopped");
  chk_marker_width: assert property (
    $rose(ucyc_marker) |-> ##49 ucyc_marker ##1 !ucyc_marker)
    else $error("marker width");
  chk_ucyc_period: assert property (
    $rose(ucyc_marker) |-> ##200 $rose(ucyc_marker))
    else $error("microcycle length");
  chk_strobe_span: assert property (
    $rose(bus_drive_strobe) |-> ##299 bus_drive_strobe ##1 !bus_drive_strobe)
    else $error("strobe span");
  chk_ack_cause: assert property (
    $rose(receive_acknowledge) |-> bus_drive_strobe)
    else $error("ack without strobe");
  chk_ack_release: assert property (
    $fell(bus_drive_strobe) |-> ##[0:2] !receive_acknowledge)
    else $error("ack held");
  chk_resp_waits: assert property (s_bus_oe |-> !bus_drive_strobe)
    else $error("data during strobe");
  chk_ack_timing: assert property (
    $rose(bus_drive_strobe) |-> ##126 $rose(receive_acknowledge))
    else $error("address capture slot");
  cover property ($fell(bus_drive_strobe));
  cover property ($rose(s_bus_oe));
  cover property ($fell(running_indicator));
endmodule

// ### tb/test_byte_exchange_bus_read.sv
`timescale 1ns/1ps
module test_byte_exchange_bus_read;
  logic clk, rst, req, grant, stop, busy, done, cap_valid, selected;
  logic [15:0] addr, base, cap_addr;
  logic [1:0] wt;
  logic [7:0] rdata, dev_data;
  logic [8:0] upc;
  logic [31:0] seed = 32'hb17c386b;
  logic [15:0] dq[$];
  logic [15:0] aq[$];
  int fails = 0;
  int checks = 0;
  int n_run;
  logic [15:0] exp_d, exp_a;
  localparam int UCYC = bxb_pkg::SLOTS_PER_UCYC * bxb_pkg::SLOT_CYC;
  bxb_if bus_c();
  bxb_master bxb_master_i (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_rd_req(req), .i_rd_addr(addr), .i_rd_wait(wt), .i_bus_grant(grant),
    .o_rd_busy(busy), .o_rd_done(done), .o_rd_data(rdata), .o_upc(upc),
    .bus(bus_c.master));
  bxb_responder bxb_responder_i (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_stop(stop), .i_base_addr(base), .i_rd_data(dev_data),
    .o_cap_addr(cap_addr), .o_cap_valid(cap_valid), .o_selected(selected),
    .bus(bus_c.responder));
  bxb_props bxb_props_i (.i_ref_clk(clk), .i_sys_rst(rst),
    .m_bus_oe(bus_c.m_bus_oe), .s_bus_oe(bus_c.s_bus_oe),
    .bus_drive_strobe(bus_c.bus_drive_strobe),
    .transfer_direction(bus_c.transfer_direction),
    .running_indicator(bus_c.running_indicator),
    .ucyc_marker(bus_c.ucyc_marker),
    .receive_acknowledge(bus_c.receive_acknowledge));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] w,
                    input logic [7:0] e);
    int n;
    n = 0;
    addr = a;
    wt = w;
    req = 1'b1;
    dq.push_back({8'h00, e});
    aq.push_back(a);
    // First take after reset waits two microcycle ends
    while (busy !== 1'b1 && n < 500) begin
      @(posedge clk); #1 n++;
    end
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1500) begin
      @(posedge clk); #1 n++;
    end
    chk(16'(n), 16'((3 + w) * UCYC));
    chk({15'h0, selected}, {15'h0, a == base});
    @(posedge clk); #1;
  endtask
  // Request held long enough to span two microcycle ends
  task automatic refuse;
    int n;
    n = 0;
    req = 1'b1;
    repeat (400) begin
      @(posedge clk); #1 n += int'(busy);
    end
    req = 1'b0;
    chk(16'(n), 16'h0);
  endtask
  // ----------
  // Result watcher, off the launching edge
  // ----------
  always @(negedge clk) begin
    if (done === 1'b1) begin
      exp_d = dq.size() ? dq.pop_front() : 16'hdead;
      chk({8'h00, rdata}, exp_d);
    end
    if (cap_valid === 1'b1) begin
      exp_a = aq.size() ? aq.pop_front() : 16'hdead;
      chk(cap_addr, exp_a);
    end
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    grant = 1'b1;
    stop = 1'b0;
    addr = 16'h0000;
    wt = 2'h0;
    base = 16'h0000;
    dev_data = 8'h00;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      base = seed[15:0];
      dev_data = seed[23:16];
      rd(i[2] ? base ^ 16'h8000 : base, i[1:0],
         i[2] ? 8'hff : dev_data);
    end
    grant = 1'b0;
    refuse();
    grant = 1'b1;
    stop = 1'b1;
    repeat (400) @(posedge clk);
    #1 chk({15'h0, bus_c.running_indicator}, 16'h0);
    refuse();
    // Single step: one run pulse buys one microcycle of running
    @(posedge bus_c.ucyc_marker);
    @(posedge clk);
    #1 stop = 1'b0;
    @(posedge clk);
    #1 stop = 1'b1;
    n_run = 0;
    repeat (600) begin
      @(posedge clk); #1 n_run += int'(bus_c.running_indicator);
    end
    chk(16'(n_run), 16'(UCYC));
    stop = 1'b0;
    // Reset lands while the strobe is high, before any address capture
    req = 1'b1;
    while (busy !== 1'b1) begin
      @(posedge clk); #1;
    end
    repeat (40) @(posedge clk);
    #1 rst = 1'b1;
    req = 1'b0;
    @(posedge clk);
    #1 chk({7'h0, upc}, {7'h0, bxb_pkg::START_ADDR});
    chk({15'h0, bus_c.bus_drive_strobe}, 16'h0);
    rst = 1'b0;
    rd(base, 2'h0, dev_data);
    report_and_stop();
  end
  initial begin
    #1_000_000;
    fails++;
    report_and_stop();
  end
endmodule
